// ---- inc/sfcr_cfg.svh ----
// Register indices, field positions, reset values and rate constants of the
// sensor front-end configuration register bank.
// Assumes a word-indexed register port; every index below is a register number.
`ifndef SFCR_CFG_SVH
`define SFCR_CFG_SVH

// ============================================================================
// Register indices
`define SFCR_REG_SAMPLE   6'h00
`define SFCR_REG_CHAN     6'h01
`define SFCR_REG_MODE     6'h02
`define SFCR_REG_CLK      6'h05
`define SFCR_REG_LIMIT    6'h07
`define SFCR_REG_BW       6'h0D
`define SFCR_REG_OFSP     6'h0E
`define SFCR_REG_OFSN     6'h0F
`define SFCR_REG_PAR      6'h10
`define SFCR_REG_FRST     6'h24
`define SFCR_REG_GAIN1    6'h25
`define SFCR_REG_EXCITATION_REF_TRIM    6'h28
`define SFCR_REG_DOS      6'h2B
`define SFCR_REG_GAIN2    6'h2C

// ============================================================================
// Field low bit positions
`define SFCR_SMP_LSB      0
`define SFCR_RDY_BIT      24
`define SFCR_CHAN_LSB     0
`define SFCR_LVM_BIT      30
`define SFCR_DF_LSB       23
`define SFCR_CLK_LSB      25
`define SFCR_LIMIT_LSB    20
`define SFCR_BW_LSB       4
`define SFCR_OFS_LSB      0
`define SFCR_PAR1_LSB     24
`define SFCR_PAR2_LSB     16
`define SFCR_PAR3_LSB     8
`define SFCR_PAR4_LSB     0
`define SFCR_FRST_BIT     26
`define SFCR_DGAIN_LSB    0
`define SFCR_GAIN1_LSB    27
`define SFCR_EXCITATION_REF_TRIM_LSB    6
`define SFCR_RATE_BIT     23
`define SFCR_DOS_LSB      21
`define SFCR_GAIN2_LSB    2

// ============================================================================
// Reset values
`define SFCR_RST_CHAN     2'h1
`define SFCR_RST_DF       3'h3
`define SFCR_RST_CLK      7'h64
`define SFCR_RST_LIMIT    12'hFFF
`define SFCR_RST_BW       4'hF
`define SFCR_RST_OFS      13'h1623
`define SFCR_RST_PAR      8'h00
`define SFCR_RST_FRST     1'h1
`define SFCR_RST_DGAIN    20'h001F4
`define SFCR_RST_GAIN1    4'hB
`define SFCR_RST_EXCITATION_REF_TRIM    4'h0
`define SFCR_RST_RATE     1'h0
`define SFCR_RST_DOS      2'h0
`define SFCR_RST_GAIN2    3'h5

// ============================================================================
// Codes and rate constants
`define SFCR_CHAN_FIRST   2'h1
`define SFCR_CHAN_SECOND  2'h2
`define SFCR_DOS_DROOP    2'h0
`define SFCR_DOS_HALFBAND 2'h1
`define SFCR_DOS_COMB     2'h2
`define SFCR_CLK_SYS_KHZ  200000
`define SFCR_FS_KHZ_CODE  4
`define SFCR_DECIM_BASE   256
`define SFCR_DECIM_LOG2   8
`define SFCR_GAIN_SHIFT   9

`endif

// ---- inc/sfcr_pkg.sv ----
// Types shared by the sensor front-end configuration bank and its scaler.
// Assumes nothing of its surroundings.
package sfcr_pkg;
	// ========================================================================
	// Data types
	typedef logic signed [23:0] sfcr_sample_t;
	typedef logic signed [25:0] sfcr_stage_t;
	typedef logic        [1:0]  sfcr_osel_t;
endpackage : sfcr_pkg

// ---- rtl/sfcr_scale.sv ----
// Digital gain and output limiter of the sample path.
// Assumes synchronous inputs on the system clock and a synchronised reset.
`timescale 1ns/1ps
`default_nettype none
`include "sfcr_cfg.svh"

module sfcr_scale #(
	parameter int IN_W  = 26,
	parameter int G_W   = 20,
	parameter int SHIFT = `SFCR_GAIN_SHIFT
) (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic                   in_valid,
	input  wire logic signed [IN_W-1:0] in_data,
	input  wire logic signed [G_W-1:0]  gain,
	input  wire logic        [11:0]     limit,
	output logic                        out_valid,
	output sfcr_pkg::sfcr_sample_t      out_data
);
	import sfcr_pkg::*;

	localparam int P_W = IN_W + G_W;

	logic signed [P_W-1:0] prod_reg;
	logic                  prod_vld_reg;
	logic        [11:0]    limit_reg;
	logic signed [P_W-1:0] scaled;
	logic signed [P_W-1:0] lim_pos;
	logic signed [P_W-1:0] lim_neg;

	// ========================================================================
	// Gain stage
	// The gain is signed, so a negative code inverts the output polarity.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prod_reg     <= '0;
			prod_vld_reg <= 1'b0;
			limit_reg    <= `SFCR_RST_LIMIT;
		end else begin
			prod_reg     <= in_data * gain;
			prod_vld_reg <= in_valid;
			limit_reg    <= limit;
		end
	end

	// ========================================================================
	// Limiter
	// A full-scale limit code opens the clamp to the whole 24-bit range.
	assign scaled  = prod_reg >>> SHIFT;
	assign lim_pos = P_W'($signed({1'b0, limit_reg, 11'h7FF}));
	assign lim_neg = -lim_pos - P_W'(1);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end else begin
			out_valid <= prod_vld_reg;
			if (prod_vld_reg) begin
				if (scaled > lim_pos) begin
					out_data <= sfcr_sample_t'(lim_pos);
				end else if (scaled < lim_neg) begin
					out_data <= sfcr_sample_t'(lim_neg);
				end else begin
					out_data <= sfcr_sample_t'(scaled);
				end
			end
		end
	end

	AST_LIMIT_CLAMP: assert property (@(posedge clk) disable iff (!rst_n)
		out_valid |-> ($signed(out_data) <= $signed({1'b0, $past(limit_reg), 11'h7FF})))
		else $error("Sample exceeds the programmed limit.");

endmodule : sfcr_scale

`default_nettype wire

// ---- rtl/sfcr_regs.sv ----
// Configuration register bank and sample path of the sensor front end.
// Assumes a host-side serial engine on CLK_SYS that issues word reads and writes.
//
// What this block does
// - Channel select 1 measures first axis, 2 measures orthogonal second axis.
// - One axis converted at a time; switching is done by channel select.
// - Excitation trim resets to 0 for 2.1 V; code 15 gives 4.4 V.
// - Low-voltage mode excites at 1.2 V and ignores the excitation trim.
// - Positive and negative offset trims take codes to 8191, independently.
// - Signed digital gain scales the conversion result; resets to 500.
// - Each sample is a ready flag followed by 24 two's complement bits.
// - Rate factor bit selects R of 1 or 2; resets to 0.
// - Seven-bit clock setting sets the sampling rate; resets to 100.
// - Output select: 0 droop stage, 1 half-band stage, 2 comb stage.
// - Twelve-bit limiter clamps output magnitude; 4095 means no limiting.
// - Filter reset bit 26 holds the decimation filter reset; resets to 1.
// - Output rate is sampling rate over 256 times 2^factor times R.
`timescale 1ns/1ps
`default_nettype none
`include "sfcr_cfg.svh"

module sfcr_regs #(
	parameter int unsigned CLK_KHZ = `SFCR_CLK_SYS_KHZ
) (
	input  wire logic                 CLK_SYS,
	input  wire logic                 RESETN,
	input  wire logic [5:0]           REG_ADDR,
	input  wire logic [31:0]          REG_WDATA,
	input  wire logic                 REG_WR,
	input  wire logic                 REG_RD,
	output logic      [31:0]          REG_RDATA,
	output logic                      REG_RVALID,
	input  wire sfcr_pkg::sfcr_sample_t SENSE_FIRST,
	input  wire sfcr_pkg::sfcr_sample_t SENSE_SECOND,
	output logic                      CHAN_SECOND,
	output logic      [3:0]           EXC_TRIM,
	output logic                      EXC_LOW_VOLT,
	output logic      [3:0]           GAIN_FIRST,
	output logic      [2:0]           GAIN_SECOND,
	output logic      [3:0]           BANDWIDTH,
	output logic      [12:0]          OFFSET_POS,
	output logic      [12:0]          OFFSET_NEG,
	output logic      [7:0]           PARASITIC_FIRST,
	output logic      [7:0]           PARASITIC_SECOND,
	output logic      [7:0]           PARASITIC_THIRD,
	output logic      [7:0]           PARASITIC_FOURTH,
	output logic                      SAMPLE_READY,
	output sfcr_pkg::sfcr_sample_t    SAMPLE_DATA
);
	import sfcr_pkg::*;

	localparam int WIN_W = 17;
	localparam int ACC_W = 41;

	logic rst_meta_reg, rst_n;
	logic [1:0] chan_sel_reg;
	logic [2:0] decim_reg;
	logic [6:0] clk_set_reg;
	logic [11:0] limit_reg;
	logic [3:0] bw_reg, gain1_reg, excitation_ref_trim_reg;
	logic [2:0] gain2_reg;
	logic [12:0] ofsp_reg, ofsn_reg;
	logic [7:0] par1_reg, par2_reg, par3_reg, par4_reg;
	logic frst_reg, lvm_reg, rate_reg;
	logic signed [19:0] dgain_reg;
	sfcr_osel_t dos_reg;
	logic chan_second_reg, exc_low_reg;
	logic [3:0] exc_trim_reg;
	sfcr_sample_t first_meta_reg, first_sync_reg, second_meta_reg, second_sync_reg;
	logic [17:0] fs_acc_reg;
	logic [18:0] fs_sum;
	logic fs_tick;
	logic [WIN_W-1:0] win_cnt_reg, win_target;
	logic win_last;
	logic signed [ACC_W-1:0] acc_reg, acc_sum;
	logic [3:0] avg_shift;
	sfcr_stage_t cic_cur_reg, cic_prev_reg, stage_reg, stage_sel;
	logic cic_vld_reg, stage_vld_reg;
	logic scaled_valid;
	sfcr_sample_t scaled_data;
	logic ready_reg;
	sfcr_sample_t data_reg;
	logic [31:0] rd_word;
	logic wr_hit_sample_rd;

	// ========================================================================
	// Reset release
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			rst_meta_reg <= 1'b0;
			rst_n        <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n        <= rst_meta_reg;
		end
	end

	// ========================================================================
	// Configuration fields
	// Each field decodes only its own bits, so a write to a shared word sets
	// every field of that word; the host rewrites neighbours it wants kept.
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			chan_sel_reg <= `SFCR_RST_CHAN;
			decim_reg    <= `SFCR_RST_DF;
			lvm_reg      <= 1'b0;
			clk_set_reg  <= `SFCR_RST_CLK;
			limit_reg    <= `SFCR_RST_LIMIT;
			bw_reg       <= `SFCR_RST_BW;
			ofsp_reg     <= `SFCR_RST_OFS;
			ofsn_reg     <= `SFCR_RST_OFS;
			par1_reg     <= `SFCR_RST_PAR;
			par2_reg     <= `SFCR_RST_PAR;
			par3_reg     <= `SFCR_RST_PAR;
			par4_reg     <= `SFCR_RST_PAR;
			frst_reg     <= `SFCR_RST_FRST;
			dgain_reg    <= `SFCR_RST_DGAIN;
			gain1_reg    <= `SFCR_RST_GAIN1;
			excitation_ref_trim_reg    <= `SFCR_RST_EXCITATION_REF_TRIM;
			rate_reg     <= `SFCR_RST_RATE;
			dos_reg      <= `SFCR_RST_DOS;
			gain2_reg    <= `SFCR_RST_GAIN2;
		end else if (REG_WR) begin
			case (REG_ADDR)
				`SFCR_REG_CHAN: chan_sel_reg <= REG_WDATA[`SFCR_CHAN_LSB +: 2];
				`SFCR_REG_MODE: begin
					lvm_reg   <= REG_WDATA[`SFCR_LVM_BIT];
					decim_reg <= REG_WDATA[`SFCR_DF_LSB +: $bits(decim_reg)];
				end
				`SFCR_REG_CLK:   clk_set_reg <= REG_WDATA[`SFCR_CLK_LSB +: $bits(clk_set_reg)];
				`SFCR_REG_LIMIT: limit_reg <= REG_WDATA[`SFCR_LIMIT_LSB +: $bits(limit_reg)];
				`SFCR_REG_BW:    bw_reg <= REG_WDATA[`SFCR_BW_LSB +: $bits(bw_reg)];
				`SFCR_REG_OFSP:  ofsp_reg <= REG_WDATA[`SFCR_OFS_LSB +: $bits(ofsp_reg)];
				`SFCR_REG_OFSN: begin
					par1_reg <= REG_WDATA[`SFCR_PAR1_LSB +: $bits(par1_reg)];
					par2_reg <= REG_WDATA[`SFCR_PAR2_LSB +: $bits(par2_reg)];
					ofsn_reg <= REG_WDATA[`SFCR_OFS_LSB +: $bits(ofsn_reg)];
				end
				`SFCR_REG_PAR: begin
					par3_reg <= REG_WDATA[`SFCR_PAR3_LSB +: $bits(par3_reg)];
					par4_reg <= REG_WDATA[`SFCR_PAR4_LSB +: $bits(par4_reg)];
				end
				`SFCR_REG_FRST: begin
					frst_reg  <= REG_WDATA[`SFCR_FRST_BIT];
					dgain_reg <= REG_WDATA[`SFCR_DGAIN_LSB +: $bits(dgain_reg)];
				end
				`SFCR_REG_GAIN1: gain1_reg <= REG_WDATA[`SFCR_GAIN1_LSB +: $bits(gain1_reg)];
				`SFCR_REG_EXCITATION_REF_TRIM: excitation_ref_trim_reg <= REG_WDATA[`SFCR_EXCITATION_REF_TRIM_LSB +: $bits(excitation_ref_trim_reg)];
				`SFCR_REG_DOS: begin
					rate_reg <= REG_WDATA[`SFCR_RATE_BIT];
					dos_reg  <= REG_WDATA[`SFCR_DOS_LSB +: $bits(dos_reg)];
				end
				`SFCR_REG_GAIN2: gain2_reg <= REG_WDATA[`SFCR_GAIN2_LSB +: $bits(gain2_reg)];
				default: ;
			endcase
		end
	end

	// ========================================================================
	// Front-end controls
	// Channel codes other than 1 and 2 keep the axis already in use, so the
	// converter never sees an undefined input.
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			chan_second_reg <= 1'b0;
			exc_trim_reg    <= `SFCR_RST_EXCITATION_REF_TRIM;
			exc_low_reg     <= 1'b0;
		end else begin
			if (chan_sel_reg == `SFCR_CHAN_FIRST) begin
				chan_second_reg <= 1'b0;
			end else if (chan_sel_reg == `SFCR_CHAN_SECOND) begin
				chan_second_reg <= 1'b1;
			end
			exc_low_reg  <= lvm_reg;
			exc_trim_reg <= lvm_reg ? `SFCR_RST_EXCITATION_REF_TRIM : excitation_ref_trim_reg;
		end
	end

	assign CHAN_SECOND      = chan_second_reg;
	assign EXC_TRIM         = exc_trim_reg;
	assign EXC_LOW_VOLT     = exc_low_reg;
	assign GAIN_FIRST       = gain1_reg;
	assign GAIN_SECOND      = gain2_reg;
	assign BANDWIDTH        = bw_reg;
	assign OFFSET_POS       = ofsp_reg;
	assign OFFSET_NEG       = ofsn_reg;
	assign PARASITIC_FIRST  = par1_reg;
	assign PARASITIC_SECOND = par2_reg;
	assign PARASITIC_THIRD  = par3_reg;
	assign PARASITIC_FOURTH = par4_reg;

	// ========================================================================
	// Converter input capture
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			first_meta_reg  <= '0;
			first_sync_reg  <= '0;
			second_meta_reg <= '0;
			second_sync_reg <= '0;
		end else begin
			first_meta_reg  <= SENSE_FIRST;
			first_sync_reg  <= first_meta_reg;
			second_meta_reg <= SENSE_SECOND;
			second_sync_reg <= second_meta_reg;
		end
	end

	// ========================================================================
	// Sampling clock
	// A phase accumulator gives the sampling rate in steps of one clock
	// setting code without a divider; the tick jitters by one system cycle.
	assign fs_sum  = {1'b0, fs_acc_reg} + 19'(clk_set_reg) * 19'(`SFCR_FS_KHZ_CODE);
	assign fs_tick = (fs_sum >= 19'(CLK_KHZ));

	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			fs_acc_reg <= '0;
		end else begin
			fs_acc_reg <= fs_tick ? 18'(fs_sum - 19'(CLK_KHZ)) : fs_acc_reg + 18'(fs_sum - {1'b0, fs_acc_reg});
		end
	end

	// ========================================================================
	// Decimation filter
	assign win_target = WIN_W'(`SFCR_DECIM_BASE) << decim_reg << rate_reg;
	assign win_last   = (win_cnt_reg == win_target - WIN_W'(1));
	assign acc_sum    = acc_reg + ACC_W'(chan_second_reg ? second_sync_reg : first_sync_reg);
	assign avg_shift  = 4'(`SFCR_DECIM_LOG2) + 4'(decim_reg) + 4'(rate_reg);

	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			win_cnt_reg  <= '0;
			acc_reg      <= '0;
			cic_cur_reg  <= '0;
			cic_prev_reg <= '0;
			cic_vld_reg  <= 1'b0;
		end else if (frst_reg) begin
			win_cnt_reg  <= '0;
			acc_reg      <= '0;
			cic_cur_reg  <= '0;
			cic_prev_reg <= '0;
			cic_vld_reg  <= 1'b0;
		end else begin
			cic_vld_reg <= fs_tick && win_last;
			if (fs_tick) begin
				win_cnt_reg <= win_last ? '0 : win_cnt_reg + WIN_W'(1);
				acc_reg     <= win_last ? '0 : acc_sum;
				if (win_last) begin
					cic_cur_reg  <= sfcr_stage_t'(acc_sum >>> avg_shift);
					cic_prev_reg <= cic_cur_reg;
				end
			end
		end
	end

	// The half-band and droop stages are two-tap approximations; bypassing
	// to the comb output trades flatness for latency.
	always_comb begin
		unique case (dos_reg)
			`SFCR_DOS_HALFBAND: stage_sel = (cic_cur_reg + cic_prev_reg) >>> 1;
			`SFCR_DOS_COMB:     stage_sel = cic_cur_reg;
			default:            stage_sel = cic_cur_reg + ((cic_cur_reg - cic_prev_reg) >>> 2);
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			stage_reg     <= '0;
			stage_vld_reg <= 1'b0;
		end else begin
			stage_vld_reg <= cic_vld_reg && !frst_reg;
			if (cic_vld_reg) begin
				stage_reg <= stage_sel;
			end
		end
	end

	sfcr_scale #(
		.IN_W  ($bits(sfcr_stage_t)),
		.G_W   ($bits(dgain_reg)),
		.SHIFT (`SFCR_GAIN_SHIFT)
	) u_scale (
		.clk       (CLK_SYS),
		.rst_n     (rst_n),
		.in_valid  (stage_vld_reg),
		.in_data   (stage_reg),
		.gain      (dgain_reg),
		.limit     (limit_reg),
		.out_valid (scaled_valid),
		.out_data  (scaled_data)
	);

	// ========================================================================
	// Sample holding and register reads
	// A new sample arriving in the cycle that reads the old one keeps the
	// ready flag set so the sample is not lost.
	assign wr_hit_sample_rd = REG_RD && (REG_ADDR == `SFCR_REG_SAMPLE);

	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			ready_reg <= 1'b0;
			data_reg  <= '0;
		end else begin
			if (scaled_valid) begin
				ready_reg <= 1'b1;
				data_reg  <= scaled_data;
			end else if (wr_hit_sample_rd) begin
				ready_reg <= 1'b0;
			end
		end
	end

	assign SAMPLE_READY = ready_reg;
	assign SAMPLE_DATA  = data_reg;

	always_comb begin
		rd_word = '0;
		case (REG_ADDR)
			`SFCR_REG_SAMPLE: begin
				rd_word[`SFCR_RDY_BIT]                = ready_reg;
				rd_word[`SFCR_SMP_LSB +: $bits(data_reg)] = data_reg;
			end
			`SFCR_REG_CHAN: rd_word[`SFCR_CHAN_LSB +: 2] = chan_sel_reg;
			`SFCR_REG_MODE: begin
				rd_word[`SFCR_LVM_BIT]                   = lvm_reg;
				rd_word[`SFCR_DF_LSB +: $bits(decim_reg)] = decim_reg;
			end
			`SFCR_REG_CLK:   rd_word[`SFCR_CLK_LSB +: $bits(clk_set_reg)] = clk_set_reg;
			`SFCR_REG_LIMIT: rd_word[`SFCR_LIMIT_LSB +: $bits(limit_reg)] = limit_reg;
			`SFCR_REG_BW:    rd_word[`SFCR_BW_LSB +: $bits(bw_reg)] = bw_reg;
			`SFCR_REG_OFSP:  rd_word[`SFCR_OFS_LSB +: $bits(ofsp_reg)] = ofsp_reg;
			`SFCR_REG_OFSN: begin
				rd_word[`SFCR_PAR1_LSB +: $bits(par1_reg)] = par1_reg;
				rd_word[`SFCR_PAR2_LSB +: $bits(par2_reg)] = par2_reg;
				rd_word[`SFCR_OFS_LSB +: $bits(ofsn_reg)]  = ofsn_reg;
			end
			`SFCR_REG_PAR: begin
				rd_word[`SFCR_PAR3_LSB +: $bits(par3_reg)] = par3_reg;
				rd_word[`SFCR_PAR4_LSB +: $bits(par4_reg)] = par4_reg;
			end
			`SFCR_REG_FRST: begin
				rd_word[`SFCR_FRST_BIT]                     = frst_reg;
				rd_word[`SFCR_DGAIN_LSB +: $bits(dgain_reg)] = dgain_reg;
			end
			`SFCR_REG_GAIN1: rd_word[`SFCR_GAIN1_LSB +: $bits(gain1_reg)] = gain1_reg;
			`SFCR_REG_EXCITATION_REF_TRIM: rd_word[`SFCR_EXCITATION_REF_TRIM_LSB +: $bits(excitation_ref_trim_reg)] = excitation_ref_trim_reg;
			`SFCR_REG_DOS: begin
				rd_word[`SFCR_RATE_BIT]                 = rate_reg;
				rd_word[`SFCR_DOS_LSB +: $bits(dos_reg)] = dos_reg;
			end
			`SFCR_REG_GAIN2: rd_word[`SFCR_GAIN2_LSB +: $bits(gain2_reg)] = gain2_reg;
			default: ;
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			REG_RDATA  <= '0;
			REG_RVALID <= 1'b0;
		end else begin
			REG_RVALID <= REG_RD;
			if (REG_RD) begin
				REG_RDATA <= rd_word;
			end
		end
	end

	// ========================================================================
	// Checks
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!rst_n);

	sequence seq_reset_held;
		frst_reg ##1 frst_reg;
	endsequence

	sequence seq_offset_write;
		REG_WR && (REG_ADDR == `SFCR_REG_OFSP);
	endsequence

	AST_CHAN_SECOND: assert property (
		(chan_sel_reg == `SFCR_CHAN_SECOND) |=> CHAN_SECOND)
		else $error("Second axis not selected for code 2.");
	AST_CHAN_HOLD: assert property (
		(chan_sel_reg != `SFCR_CHAN_FIRST) && (chan_sel_reg != `SFCR_CHAN_SECOND)
		|=> $stable(CHAN_SECOND))
		else $error("Axis changed on an illegal channel code.");
	AST_TRIM_RESET: assert property (
		$rose(rst_n) |-> (excitation_ref_trim_reg == 4'h0) && (EXC_TRIM == 4'h0))
		else $error("Excitation trim not zero after reset.");
	AST_LOW_VOLT: assert property (
		lvm_reg ##1 lvm_reg |-> EXC_LOW_VOLT && (EXC_TRIM == 4'h0))
		else $error("Trim active in low-voltage mode.");
	AST_OFFSET_SEP: assert property (
		seq_offset_write |=> (OFFSET_POS == $past(REG_WDATA[12:0])) && $stable(OFFSET_NEG))
		else $error("Offset trim write wrong or disturbed its partner.");
	AST_GAIN_RESET: assert property (
		$rose(rst_n) |-> (dgain_reg == 20'sh001F4))
		else $error("Digital gain not 500 after reset.");
	AST_SAMPLE_HOLD: assert property (
		scaled_valid |=> SAMPLE_READY && (SAMPLE_DATA == $past(scaled_data)))
		else $error("Sample not presented with ready flag.");
	AST_WINDOW_LEN: assert property (
		cic_vld_reg |-> $past(win_cnt_reg) == $past(win_target) - WIN_W'(1))
		else $error("Output emitted before the decimation window closed.");
	AST_FILTER_RESET: assert property (
		seq_reset_held |-> (win_cnt_reg == '0) && !cic_vld_reg && !stage_vld_reg)
		else $error("Decimation filter ran while held in reset.");
	AST_COMB_SELECT: assert property (
		cic_vld_reg && (dos_reg == `SFCR_DOS_COMB) |=> stage_reg == $past(cic_cur_reg))
		else $error("Comb stage output not selected for code 2.");
	AST_READBACK: assert property (
		REG_RD && (REG_ADDR == `SFCR_REG_LIMIT)
		|=> REG_RVALID && (REG_RDATA[31:20] == $past(limit_reg)))
		else $error("Limit field readback mismatch.");

endmodule : sfcr_regs

`default_nettype wire

// ---- dv/sfcr_conv_model.sv ----
// Converter stand-in driving a fixed code on each sense axis.
// Assumes the bank synchronises these inputs itself.
`timescale 1ns/1ps
`default_nettype none

module sfcr_conv_model (
	output var sfcr_pkg::sfcr_sample_t first,
	output var sfcr_pkg::sfcr_sample_t second
);
	import sfcr_pkg::*;
	// Distinct powers of two show the axis converted and keep the gain exact.
	assign first  = 24'sh000400;
	assign second = 24'sh001000;
endmodule : sfcr_conv_model
`default_nettype wire

// ---- dv/sfcr_regs_bench.sv ----
// Self-checking bench of the register bank and its sample path.
// Assumes the converter model feeds both axes with fixed codes.
`timescale 1ns/1ps
`default_nettype none

module sfcr_regs_bench;
	import sfcr_pkg::*;
	logic         clk_sys, resetn, reg_wr, reg_rd, rvalid, chan2, low_v, ready;
	logic [5:0]   addr;
	logic [31:0]  wdata, rdata, q;
	logic [3:0]   trim, g1, bw;
	logic [2:0]   g2;
	logic [7:0]   par1, par2, par3, par4;
	logic [12:0]  ofs_n, ofs_p;
	sfcr_sample_t s1, s2, sdata;
	int           n_fail, checks_done, cyc, tr, ta;
	logic [5:0]   ra [8] = '{6'h00, 6'h01, 6'h02, 6'h05, 6'h07, 6'h24, 6'h28, 6'h2B};
	logic [31:0]  rv [8] = '{32'h0, 32'h1, 32'h01800000, 32'hC8000000, 32'hFFF00000,
		32'h040001F4, 32'h0, 32'h0};

	sfcr_conv_model conv_u (.first(s1), .second(s2));
	// A slow kilohertz figure gives one sampling tick every two cycles.
	sfcr_regs #(.CLK_KHZ(800)) dut_u (.CLK_SYS(clk_sys), .RESETN(resetn), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata),
		.REG_RVALID(rvalid), .SENSE_FIRST(s1), .SENSE_SECOND(s2), .CHAN_SECOND(chan2),
		.EXC_TRIM(trim), .EXC_LOW_VOLT(low_v), .GAIN_FIRST(g1), .GAIN_SECOND(g2), .BANDWIDTH(bw),
		.OFFSET_POS(ofs_p), .OFFSET_NEG(ofs_n), .PARASITIC_FIRST(par1), .PARASITIC_SECOND(par2),
		.PARASITIC_THIRD(par3), .PARASITIC_FOURTH(par4), .SAMPLE_READY(ready),
		.SAMPLE_DATA(sdata));

	// ========
	// Clock, timeout and tasks
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_fail++;
			stop_test();
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		addr   <= a;
		wdata  <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [5:0] a);
		@(posedge clk_sys);
		addr   <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		for (int k = 0; k < 3 && rvalid !== 1'b1; k++) begin
			@(posedge clk_sys);
			#1;
		end
		q = rdata;
	endtask : rd
	task wait_ready;
		for (int k = 0; k < 4000 && ready !== 1'b1; k++) begin
			@(posedge clk_sys);
			#1;
		end
		tr = cyc;
		chk(ready, 1'b1);
	endtask : wait_ready
	// Two samples, so the second one never straddles a setting change.
	task next_sample;
		repeat (2) begin
			rd(6'h00);
			wait_ready();
		end
		rd(6'h00);
	endtask : next_sample
	task period(input int p);
		rd(6'h00);
		wait_ready();
		ta = tr;
		rd(6'h00);
		chk(ready, 1'b0);
		wait_ready();
		chk(32'(tr - ta), 32'(p));
	endtask : period
	task stop_test;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : stop_test

	// ========
	// Main sequence
	initial begin
		resetn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		addr   = 6'h00;
		wdata  = 32'h0;
		repeat (8) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		for (int i = 0; i < 8; i++) begin
			rd(ra[i]);
			chk(q, rv[i]);
		end
		wr(6'h01, 32'h2);
		rd(6'h01);
		chk(chan2, 1'b1);
		wr(6'h0F, 32'hB6361FFF);
		wr(6'h10, 32'h000036B6);
		wr(6'h3F, 32'hFFFFFFFF);
		rd(6'h0F);
		chk(q, 32'hB6361FFF);
		chk({par1, 11'h0, ofs_n}, {8'hB6, 11'h0, 13'h1FFF});
		chk({par1, par2, par3, par4}, 32'hB63636B6);
		rd(6'h3F);
		chk(q, 32'h0);
		wr(6'h01, 32'h3);
		rd(6'h01);
		chk(chan2, 1'b1);
		wr(6'h28, 32'h000003C0);
		rd(6'h28);
		chk(trim, 4'hF);
		wr(6'h02, 32'h40000000);
		rd(6'h02);
		chk(q, 32'h40000000);
		chk({low_v, trim}, 5'h10);
		wr(6'h25, 32'h78000000);
		wr(6'h2C, 32'h0);
		wr(6'h0D, 32'h000000F0);
		wr(6'h0E, 32'h00001623);
		wr(6'h0F, 32'hB6361623);
		wr(6'h28, 32'h0);
		rd(6'h0E);
		chk(q, 32'h00001623);
		chk({g1, g2, bw, 8'h0, ofs_p}, {4'hF, 3'h0, 4'hF, 8'h0, 13'h1623});
		chk({19'h0, ofs_n}, 32'h00001623);
		wr(6'h2B, 32'h00400000);
		wr(6'h24, 32'h000001F4);
		period(512);
		rd(6'h00);
		chk(q, 32'h01000FA0);
		wr(6'h24, 32'h000FFE00);
		wr(6'h07, 32'h0);
		next_sample();
		chk(q, 32'h01FFF800);
		chk({8'h0, sdata}, 32'h00FFF800);
		// The comb output comes last, so the axis change below settles in one window.
		for (int d = 0; d < 3; d++) begin
			wr(6'h2B, 32'(d) << 21);
			next_sample();
			chk(q, 32'h01FFF800);
		end
		wr(6'h01, 32'h1);
		next_sample();
		chk(q, 32'h01FFFC00);
		wr(6'h2B, 32'h00C00000);
		wr(6'h24, 32'h040FFE00);
		wr(6'h24, 32'h000FFE00);
		period(1024);
		stop_test();
	end
endmodule : sfcr_regs_bench
`default_nettype wire
